/* File: pkg/tms_pkg.sv */
// translation mode select package: register map, field layout, types
// assumes an avalon-mm slave with 32-bit words, byte addresses
package tms_pkg;
   localparam int unsigned NUM_CHAN      = 2;
   localparam int unsigned NUM_PROF      = 6;
   localparam int unsigned FB_W          = 5;
   localparam int unsigned ADDR_W        = 12;
   // per-profile word: channel stride and profile stride in bytes
   localparam logic [11:0] PROF_BASE     = 12'h000;
   localparam logic [11:0] CHAN_STRIDE   = 12'h100;
   localparam logic [11:0] PROF_STRIDE   = 12'h010;
   localparam logic [11:0] OFF_MODE      = 12'h000;
   localparam logic [11:0] OFF_FBPATH    = 12'h004;
   // per-channel control, status, clear
   localparam logic [11:0] OFF_CTRL      = 12'h800;
   localparam logic [11:0] OFF_STATUS    = 12'h804;
   localparam logic [11:0] OFF_CLEAR     = 12'h808;
   localparam logic [11:0] OFF_CFG       = 12'h80c;
   localparam logic [11:0] CTRL_STRIDE   = 12'h020;
   // field positions
   localparam int unsigned BIT_HITLESS   = 0;
   localparam int unsigned BIT_EXTZD     = 1;
   localparam int unsigned BIT_ENTERED   = 4;
   localparam int unsigned BIT_EXITED    = 3;
   localparam int unsigned BIT_TAGGED    = 0;
   localparam int unsigned BIT_SRC_ONE   = 1;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
   localparam logic [4:0]  FB_RST        = 5'h00;
   localparam logic [1:0]  MODE_RST      = 2'h0;
   typedef enum logic [1:0]
   {
      TMS_BUILDOUT,
      TMS_INT_ZD,
      TMS_EXT_ZD,
      TMS_INVALID
   } tms_mode_t;
   // selected feedback source per channel
   typedef struct packed {
      logic       int_valid;  // one of the output pins
      logic [2:0] out_pin;    // 0..3 pair a/b p,n; 4,5 pair c p,n
      logic       ext_valid;  // one of the reference inputs
      logic [1:0] ref_in;     // first..fourth reference input
   } tms_fb_sel_t;
   // rate relation flags per channel
   typedef struct packed {
      logic        ref_div_unity;
      logic        use_frac;
      logic        phase_offset_buildout;
      logic        slew_toward_ref;
      logic        tagged_fb;
   } tms_rate_t;
endpackage

/* File: rtl/tms_translation_mode.sv */
// translation mode select for two digital loops, six profiles each
// assumes a single 100 MHz mclk and an avalon-mm master; profile select
// and offset measurement come from same-clock loop logic
`timescale 1ns/1ps
module tms_translation_mode
(
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst,
   // avalon-mm slave
   input  wire logic [tms_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [31:0]                   avs_writedata,
   input  wire logic [3:0]                    avs_byteenable,
   output logic      [31:0]                   avs_readdata,
   output logic                               avs_waitrequest,
   // loop side: active profile and reference switch events
   input  wire logic [2:0]                    active_prof [2],
   input  wire logic [1:0]                    ref_switch,
   input  wire logic [31:0]                   measured_offset [2],
   // loop side: outputs
   output tms_pkg::tms_mode_t                 mode [2],
   output tms_pkg::tms_fb_sel_t               fb_sel [2],
   output tms_pkg::tms_rate_t                 rate [2],
   output logic      [31:0]                   ts_offset [2]
);
   localparam int NC = tms_pkg::NUM_CHAN;
   localparam int NP = tms_pkg::NUM_PROF;

   logic [1:0]  prof_mode [NC][NP];
   logic [4:0]  prof_fb   [NC][NP];
   logic [1:0]  chan_cfg  [NC];
   logic [1:0]  sticky    [NC];
   logic [NC-1:0] hitless_q;
   logic        ack;
   logic [1:0]  next_clear [NC];
   logic        wr_hit;
   logic [1:0]  sel_mode  [NC];
   logic [4:0]  sel_fb    [NC];

   // one wait state: answer registered at the first edge that sees the request
   // fixed latency keeps the address decode off the answer path
   always_ff @(posedge mclk)
   begin
      if (rst)
         ack <= 1'b0;
      else
         ack <= (avs_read | avs_write) & ~ack;
   end
   assign wr_hit = avs_write & ack;

   // waitrequest high unless answering; comes from a flip-flop
   always_ff @(posedge mclk)
   begin
      if (rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~((avs_read | avs_write) & ~ack);
   end

   // profile and channel config register writes
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < NC; c++)
         begin
            chan_cfg[c] <= 2'h0;
            for (int p = 0; p < NP; p++)
            begin
               prof_mode[c][p] <= tms_pkg::MODE_RST;
               prof_fb[c][p]   <= tms_pkg::FB_RST;
            end
         end
      end
      else if (wr_hit && avs_byteenable[0])
      begin
         for (int c = 0; c < NC; c++)
         begin
            for (int p = 0; p < NP; p++)
            begin
               if (avs_address == tms_pkg::PROF_BASE
                   + 12'(c) * tms_pkg::CHAN_STRIDE
                   + 12'(p) * tms_pkg::PROF_STRIDE
                   + tms_pkg::OFF_MODE)
                  prof_mode[c][p] <= avs_writedata[1:0];
               if (avs_address == tms_pkg::PROF_BASE
                   + 12'(c) * tms_pkg::CHAN_STRIDE
                   + 12'(p) * tms_pkg::PROF_STRIDE
                   + tms_pkg::OFF_FBPATH)
                  prof_fb[c][p] <= avs_writedata[4:0];
            end
            if (avs_address == tms_pkg::OFF_CFG
                + 12'(c) * tms_pkg::CTRL_STRIDE)
               chan_cfg[c] <= avs_writedata[1:0];
         end
      end
   end

   // clear strobes decoded from clear-register writes
   // a set in the same cycle as a clear still wins below
   always_comb
   begin
      for (int c = 0; c < NC; c++)
      begin
         next_clear[c] = 2'b00;
         if (wr_hit && avs_byteenable[0] && avs_address
             == tms_pkg::OFF_CLEAR + 12'(c) * tms_pkg::CTRL_STRIDE)
            next_clear[c] = {avs_writedata[tms_pkg::BIT_ENTERED],
                             avs_writedata[tms_pkg::BIT_EXITED]};
      end
   end

   // read mux; unmapped addresses read zero
   always_ff @(posedge mclk)
   begin
      if (rst)
         avs_readdata <= tms_pkg::READ_UNMAPPED;
      else if (avs_read && !ack)
      begin
         avs_readdata <= tms_pkg::READ_UNMAPPED;
         for (int c = 0; c < NC; c++)
         begin
            for (int p = 0; p < NP; p++)
            begin
               if (avs_address == tms_pkg::PROF_BASE
                   + 12'(c) * tms_pkg::CHAN_STRIDE
                   + 12'(p) * tms_pkg::PROF_STRIDE
                   + tms_pkg::OFF_MODE)
                  avs_readdata <= {30'h0, prof_mode[c][p]};
               if (avs_address == tms_pkg::PROF_BASE
                   + 12'(c) * tms_pkg::CHAN_STRIDE
                   + 12'(p) * tms_pkg::PROF_STRIDE
                   + tms_pkg::OFF_FBPATH)
                  avs_readdata <= {27'h0, prof_fb[c][p]};
            end
            if (avs_address == tms_pkg::OFF_STATUS
                + 12'(c) * tms_pkg::CTRL_STRIDE)
               avs_readdata <= {27'h0, sticky[c][1], sticky[c][0],
                                2'b00, hitless_q[c]};
            if (avs_address == tms_pkg::OFF_CTRL
                + 12'(c) * tms_pkg::CTRL_STRIDE)
               avs_readdata <= {30'h0, mode[c]};
            if (avs_address == tms_pkg::OFF_CFG
                + 12'(c) * tms_pkg::CTRL_STRIDE)
               avs_readdata <= {30'h0, chan_cfg[c]};
         end
      end
   end

   // active profile fields; an index beyond five falls back to profile 0
   always_comb
   begin
      for (int c = 0; c < NC; c++)
      begin
         sel_mode[c] = prof_mode[c][0];
         sel_fb[c]   = prof_fb[c][0];
         for (int p = 1; p < NP; p++)
         begin
            if (active_prof[c] == 3'(p))
            begin
               sel_mode[c] = prof_mode[c][p];
               sel_fb[c]   = prof_fb[c][p];
            end
         end
      end
   end

   // translation mode from the profile's hitless and external bits
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < NC; c++)
            mode[c] <= tms_pkg::TMS_BUILDOUT;
      end
      else
      begin
         for (int c = 0; c < NC; c++)
         begin
            unique case (sel_mode[c])
               2'b00: mode[c] <= tms_pkg::TMS_BUILDOUT;
               2'b01: mode[c] <= tms_pkg::TMS_INT_ZD;
               2'b11: mode[c] <= tms_pkg::TMS_EXT_ZD;
               2'b10: mode[c] <= tms_pkg::TMS_INVALID;
            endcase
         end
      end
   end

   // feedback source decode; pair c exists only on channel 0
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < NC; c++)
            fb_sel[c] <= '0;
      end
      else
      begin
         for (int c = 0; c < NC; c++)
         begin
            fb_sel[c].int_valid <= (sel_mode[c] == 2'b01) &&
                                   ((sel_fb[c] < 5'd4) ||
                                    (c == 0 && sel_fb[c] < 5'd6));
            fb_sel[c].out_pin   <= sel_fb[c][2:0];
            fb_sel[c].ext_valid <= (sel_mode[c] == 2'b11) &&
                                   (sel_fb[c] < 5'd4);
            fb_sel[c].ref_in    <= sel_fb[c][1:0];
         end
      end
   end

   // rate relation flags for the loop's divider arithmetic
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < NC; c++)
            rate[c] <= '0;
      end
      else
      begin
         for (int c = 0; c < NC; c++)
         begin
            rate[c].use_frac <= (sel_mode[c] == 2'b00);
            // oscillator or other-loop source: unity divide in every mode
            rate[c].ref_div_unity <=
               chan_cfg[c][tms_pkg::BIT_SRC_ONE];
            rate[c].phase_offset_buildout <=
               (sel_mode[c] == 2'b00);
            // hitless modes slew toward the reference instead
            rate[c].slew_toward_ref <= sel_mode[c][0];
            rate[c].tagged_fb <= chan_cfg[c][tms_pkg::BIT_TAGGED] &
                                 (sel_mode[c] == 2'b01);
         end
      end
   end

   // buildout offset latched on a reference switch
   // hitless modes load zero: the slew closes the gap there
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int c = 0; c < NC; c++)
            ts_offset[c] <= 32'h0;
      end
      else
      begin
         for (int c = 0; c < NC; c++)
            if (ref_switch[c])
               ts_offset[c] <= (mode[c] == tms_pkg::TMS_BUILDOUT)
                               ? measured_offset[c] : 32'h0;
      end
   end

   // hitless entry/exit sticky bits; set wins over clear
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         hitless_q <= '0;
         for (int c = 0; c < NC; c++)
            sticky[c] <= 2'b00;
      end
      else
      begin
         for (int c = 0; c < NC; c++)
         begin
            logic hl;
            // invalid mode counts as not hitless
            hl = (mode[c] == tms_pkg::TMS_INT_ZD) ||
                 (mode[c] == tms_pkg::TMS_EXT_ZD);
            hitless_q[c] <= hl;
            sticky[c][1] <= (hl & ~hitless_q[c]) |
                            (sticky[c][1] & ~next_clear[c][1]);
            sticky[c][0] <= (~hl & hitless_q[c]) |
                            (sticky[c][0] & ~next_clear[c][0]);
         end
      end
   end
endmodule // tms_translation_mode

/* File: tb/tms_host.sv */
// host side partner: avalon-mm master for configuration software
// assumes one mclk; the slave answers through waitrequest
`timescale 1ns/1ps
module tms_host
(
   // clock
   input  wire logic        mclk,
   // avalon-mm master
   output logic [11:0]      avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   // idle bus at time zero; all four byte lanes enabled
   initial
   begin
      avs_address    = 12'h000;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hf;
   end
   // one transfer, held until waitrequest is sampled low
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~w;
      avs_write     <= w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask
endmodule // tms_host

/* File: tb/tms_translation_mode_asserts.sv */
// port checker for the translation mode select block
// assumes bind from the bench top; single mclk domain
`timescale 1ns/1ps
module tms_chk
(
   input wire logic                 mclk,
   input wire logic                 rst,
   input wire logic [11:0]          avs_address,
   input wire logic                 avs_read,
   input wire logic                 avs_write,
   input wire logic [31:0]          avs_readdata,
   input wire logic                 avs_waitrequest,
   input wire logic [1:0]           ref_switch,
   input wire logic [31:0]          measured_offset [2],
   input tms_pkg::tms_mode_t        mode [2],
   input tms_pkg::tms_fb_sel_t      fb_sel [2],
   input tms_pkg::tms_rate_t        rate [2],
   input wire logic [31:0]          ts_offset [2]
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // bus: one wait cycle, ready lasts one cycle
   property p_ack; (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_one: assert property (p_one) else $error("ready held");
   property p_unmap; avs_read && !avs_waitrequest
      && avs_address == 12'hffc |-> avs_readdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   // feedback decode tied to mode
   property p_int; fb_sel[0].int_valid |-> mode[0] == tms_pkg::TMS_INT_ZD
      && fb_sel[0].out_pin <= 3'h5; endproperty
   a_int: assert property (p_int) else $error("int sel");
   property p_ch1; fb_sel[1].int_valid |-> fb_sel[1].out_pin <= 3'h3;
   endproperty
   a_ch1: assert property (p_ch1) else $error("ch1 pin");
   property p_ext; fb_sel[0].ext_valid |-> mode[0] == tms_pkg::TMS_EXT_ZD;
   endproperty
   a_ext: assert property (p_ext) else $error("ext sel");
   // rate flags register on the same edge as mode; mode is held three cycles first
   property p_frac; (mode[0] == tms_pkg::TMS_BUILDOUT) [*3]
      |-> rate[0].use_frac && rate[0].phase_offset_buildout; endproperty
   a_frac: assert property (p_frac) else $error("frac");
   property p_slew; (mode[0] == tms_pkg::TMS_INT_ZD) [*3]
      |-> rate[0].slew_toward_ref && !rate[0].use_frac; endproperty
   a_slew: assert property (p_slew) else $error("slew");
   property p_off; ref_switch[0] && mode[0] == tms_pkg::TMS_BUILDOUT
      |=> ts_offset[0] == $past(measured_offset[0]); endproperty
   a_off: assert property (p_off) else $error("offset");
   c_int: cover property (fb_sel[0].int_valid);
   c_ext: cover property (fb_sel[0].ext_valid);
   c_sw: cover property (ref_switch[0] && mode[0] == tms_pkg::TMS_BUILDOUT);
endmodule // tms_chk

/* File: tb/tms_translation_mode_bench.sv */
// self-checking bench for the translation mode select block
// assumes tms_host as bus master; loop side driven here
`timescale 1ns/1ps
module tms_translation_mode_bench;
   logic mclk, rst, avs_read, avs_write, avs_waitrequest;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0]  avs_byteenable;
   logic [2:0]  active_prof [2];
   logic [1:0]  ref_switch;
   logic [31:0] measured_offset [2], ts_offset [2];
   tms_pkg::tms_mode_t   mode [2];
   tms_pkg::tms_fb_sel_t fb_sel [2];
   tms_pkg::tms_rate_t   rate [2];
   int n_fail, compares;
   tms_pkg::tms_mode_t ex [4] = '{tms_pkg::TMS_BUILDOUT, tms_pkg::TMS_INT_ZD,
      tms_pkg::TMS_INVALID, tms_pkg::TMS_EXT_ZD};
   tms_host u_tms_host (.mclk, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
   tms_translation_mode u_tms_translation_mode (.mclk, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_waitrequest, .active_prof, .ref_switch, .measured_offset, .mode,
      .fb_sel, .rate, .ts_offset);
   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_tms_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a);
      u_tms_host.xfer(1'b0, a, 32'h0, q);
   endtask
   // program one profile, make it active, let status settle
   task automatic setp(input int c, p, input logic [31:0] m, fb);
      logic [11:0] b;
      b = 12'(c * 256 + p * 16);
      wr(b, m);
      wr(b + tms_pkg::OFF_FBPATH, fb);
      active_prof[c] <= 3'(p);
      repeat (4) @(posedge mclk);
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++)
      begin
         setp(0, 1, 32'(m), 32'h2);
         chk("mode", 32'(ex[m]), 32'(mode[0]));
      end
      chk("ext", 32'h1, 32'(fb_sel[0].ext_valid));
      chk("ref", 32'h2, 32'(fb_sel[0].ref_in));
   endtask
   task automatic t_fb;
      for (int v = 0; v < 7; v++)
      begin
         setp(0, 2, 32'h1, 32'(v));
         chk("iv", 32'(v < 6), 32'(fb_sel[0].int_valid));
         if (v < 6) chk("pin", 32'(v), 32'(fb_sel[0].out_pin));
      end
      setp(1, 3, 32'h1, 32'h4);
      chk("iv1", 32'h0, 32'(fb_sel[1].int_valid));
      setp(1, 3, 32'h3, 32'h4);
      chk("ev1", 32'h0, 32'(fb_sel[1].ext_valid));
   endtask
   // sticky entered/exited bits, held until cleared
   task automatic t_sticky;
      setp(0, 0, 32'h0, 32'h0);
      wr(tms_pkg::OFF_CLEAR, 32'h18);
      rd(tms_pkg::OFF_STATUS);
      chk("st0", 32'h0, 32'(q[4:3]));
      setp(0, 0, 32'h1, 32'h0);
      rd(tms_pkg::OFF_STATUS);
      chk("st1", 32'h2, 32'(q[4:3]));
      setp(0, 0, 32'h0, 32'h0);
      repeat (20) @(posedge mclk);
      rd(tms_pkg::OFF_STATUS);
      chk("st2", 32'h3, 32'(q[4:3]));
      wr(tms_pkg::OFF_CLEAR, 32'h18);
      setp(0, 0, 32'h3, 32'h0);
      rd(tms_pkg::OFF_STATUS);
      chk("st3", 32'h2, 32'(q[4:3]));
   endtask
   task automatic t_misc;
      setp(0, 0, 32'h0, 32'h0);
      measured_offset[0] <= 32'h1234_5678;
      ref_switch <= 2'b01;
      @(posedge mclk);
      ref_switch <= 2'b00;
      repeat (2) @(posedge mclk);
      chk("tso", 32'h1234_5678, ts_offset[0]);
      wr(tms_pkg::OFF_CFG, 32'h3);
      setp(0, 0, 32'h1, 32'h0);
      chk("tag", 32'h1, 32'(rate[0].tagged_fb));
      chk("unity", 32'h1, 32'(rate[0].ref_div_unity));
      ref_switch <= 2'b01;
      @(posedge mclk);
      ref_switch <= 2'b00;
      repeat (2) @(posedge mclk);
      chk("tsz", 32'h0, ts_offset[0]);
      rd(12'hffc);
      chk("unmapped", 32'h0, q);
   endtask
   task automatic results;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // watchdog far beyond the expected few hundred cycles
   initial
   begin
      #200000;
      n_fail++;
      results();
   end
   initial
   begin
      rst = 1'b1;
      active_prof = '{3'h0, 3'h0};
      ref_switch = 2'b00;
      measured_offset = '{32'h0, 32'h0};
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(12'h000);
      chk("rst", 32'h0, 32'(mode[0]));
      t_modes();
      t_fb();
      t_sticky();
      t_misc();
      results();
   end
endmodule // tms_translation_mode_bench
bind tms_translation_mode tms_chk u_tms_chk (.mclk, .rst, .avs_address,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .ref_switch,
   .measured_offset, .mode, .fb_sel, .rate, .ts_offset);
